// ===== rbm_defines.vh
// constants for the receive buffer ring manager
`ifndef RBM_DEFINES_VH
`define RBM_DEFINES_VH
// ==========================================
// register offsets, page 0
`define RBM_OFS_CMD 4'h0
`define RBM_OFS_FIRST 4'h1
`define RBM_OFS_END 4'h2
`define RBM_OFS_BND 4'h3
`define RBM_OFS_ISR 4'h4
`define RBM_OFS_RCNT_LO 4'h5
`define RBM_OFS_RCNT_HI 4'h6
`define RBM_OFS_DCFG 4'h7
`define RBM_OFS_TCFG 4'h8
`define RBM_OFS_RCFG 4'h9
`define RBM_OFS_IMASK 4'hA
`define RBM_OFS_MISSED 4'hB
`define RBM_OFS_RSTAT 4'hC
// ==========================================
// register offsets, page 1
`define RBM_OFS_STA0 4'h1
`define RBM_OFS_WPP 4'h7
`define RBM_OFS_MCF0 4'h8
// ==========================================
// command register fields
`define RBM_CMD_HALT 0
`define RBM_CMD_START 1
`define RBM_CMD_TXP 2
`define RBM_CMD_PS_LO 6
`define RBM_CMD_PS_HI 7
`define RBM_CMD_RESET 8'h21
// ==========================================
// interrupt status fields
`define RBM_ISR_RX_OK 0
`define RBM_ISR_SENT 1
`define RBM_ISR_RX_ERR 2
`define RBM_ISR_SEND_ERR 3
`define RBM_ISR_OVW 4
`define RBM_ISR_RST 7
// ==========================================
// configuration fields
`define RBM_RCFG_ACC_ERR 0
`define RBM_RCFG_ACC_RUNT 1
`define RBM_TCFG_LB_LO 1
`define RBM_TCFG_LB_HI 2
// ==========================================
// buffer layout
`define RBM_HDR_BYTES 8'h04
`define RBM_PAGE_LAST 8'hFF
`define RBM_MAX_PAGES 3'h6
`define RBM_RESET_PAGE 8'h40
`endif

// ===== rbm_mem_model.sv
// buffer memory model behind the local dma write port
`timescale 1ns/10ps
module rbm_mem_model (
  input wire mclk,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_data,
  input wire mem_we
);
  // ==========================================
  // storage; unwritten bytes stay unknown so stray reads show up
  logic [7:0] mem_r [0:65535];
  int n_wr = 0;
  always @(posedge mclk) begin
    if (mem_we) begin
      mem_r[mem_addr] <= mem_data;
      n_wr <= n_wr + 1;
    end
  end
endmodule // rbm_mem_model

// ===== rbm_page_link.v
// next-page calculation with ring wrap and boundary check
`timescale 1ns/10ps
module rbm_page_link (
  cur_page,
  first_page,
  end_page,
  bnd_page,
  next_page,
  hits_bnd
);
  input wire [7:0] cur_page;
  input wire [7:0] first_page;
  input wire [7:0] end_page;
  input wire [7:0] bnd_page;
  output wire [7:0] next_page;
  output wire hits_bnd;
  wire [7:0] step;
  // ==========================================
  // forward link, the adjacent page or the first ring page at the end page
  assign step = cur_page + 8'h01;
  assign next_page = (step == end_page) ? first_page : step;
  assign hits_bnd = (next_page == bnd_page);
endmodule // rbm_page_link

// ===== rbm_ring_manager.v
// receive buffer ring manager: local receive dma, ring pointers, control registers
// Summary of operation
// - a full 256-byte page links forward to the next page for the rest
// - a legal maximum frame spans at most six linked pages
// - links never skip pages; only the ring wrap is discontinuous
// - next page equal to the end page reloads the first ring page
// - next page equal to the read boundary aborts the frame
// - otherwise the link is taken and writing continues there
// - an overflow drops only the incoming frame, stored frames stay
// - an overflow sets the overwrite warning flag
// - 22H starts and enables remote dma; loopback keeps receive dma off
// - missed frame tally does not count while halted
// - 21H selects page 0 halted, 61H selects page 1
// - writing FFH to interrupt status clears every stored flag; bit 7 reads halted-and-idle, not a flag
// - accepted frame gets status, next pointer, byte count in first page
// - rest of last page unused; write pointer takes precomputed next page
// - runt, crc or alignment errors reclaim pages unless accepted
// - the frame check bytes are stored right after the data
// - storage starts 4 bytes into the first page
// - equal pointers mean empty or full depending on who caught up
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "rbm_defines.vh"
module rbm_ring_manager (
  mclk,
  rst_n,
  ce,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  rx_start,
  rx_valid,
  rx_byte,
  rx_end,
  rx_status,
  rx_runt,
  rx_crc_err,
  rx_align_err,
  tx_sent,
  tx_error,
  mem_addr,
  mem_data,
  mem_we,
  remote_dma_en,
  rx_busy
);
  input wire mclk;
  input wire rst_n;
  input wire ce;
  input wire [3:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [7:0] reg_rdata;
  input wire rx_start;
  input wire rx_valid;
  input wire [7:0] rx_byte;
  input wire rx_end;
  input wire [7:0] rx_status;
  input wire rx_runt;
  input wire rx_crc_err;
  input wire rx_align_err;
  input wire tx_sent;
  input wire tx_error;
  output reg [15:0] mem_addr;
  output reg [7:0] mem_data;
  output reg mem_we;
  output reg remote_dma_en;
  output reg rx_busy;

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_STORE = 3'd1;
  localparam [2:0] ST_HDR0 = 3'd2;
  localparam [2:0] ST_HDR1 = 3'd3;
  localparam [2:0] ST_HDR2 = 3'd4;
  localparam [2:0] ST_HDR3 = 3'd5;

  // ==========================================
  // registers
  reg [7:0] cmd_r;
  reg halted_r;
  reg [7:0] ring_first_page_r;
  reg [7:0] ring_end_page_r;
  reg [7:0] read_boundary_pointer_r;
  reg [7:0] write_page_pointer_r;
  reg [7:0] remote_count_low_r;
  reg [7:0] remote_count_high_r;
  reg [7:0] data_config_r;
  reg [7:0] tcfg_r;
  reg [7:0] receive_config_r;
  reg [7:0] interrupt_mask_r;
  reg [7:0] missed_r;
  reg ring_full_r;
  reg [7:0] addr_book_r [0:14];
  reg [2:0] state_r;
  reg [7:0] page_r;
  reg [7:0] off_r;
  reg [15:0] count_r;
  reg [2:0] pages_r;
  reg [7:0] hdr_status_r;
  reg [7:0] next_free_r;
  reg [7:0] isr_set;
  wire [7:0] isr_flags;
  wire [7:0] link_page;
  wire link_hits_bnd;
  wire [7:0] wpp_link_page;
  wire wpp_unused;
  wire page1_sel;
  wire loopback;
  wire rx_enabled;
  wire reject;
  wire [7:0] end_next_free;

  function [15:0] page_addr;
    input [7:0] pg;
    input [7:0] ofs;
    begin
      page_addr = {pg, ofs};
    end
  endfunction

  assign page1_sel = (cmd_r[`RBM_CMD_PS_HI:`RBM_CMD_PS_LO] == 2'b01);
  assign loopback = (tcfg_r[`RBM_TCFG_LB_HI:`RBM_TCFG_LB_LO] != 2'b00);
  assign rx_enabled = !halted_r && !loopback;
  assign reject = ((rx_crc_err || rx_align_err) && !receive_config_r[`RBM_RCFG_ACC_ERR]) ||
                  (rx_runt && !receive_config_r[`RBM_RCFG_ACC_RUNT]);
  // a frame ending on a page edge has already linked into a fresh page
  assign end_next_free = (off_r == 8'h00) ? page_r : link_page;

  // ==========================================
  // page link and status flag helpers
  rbm_page_link u_link (
    .cur_page(page_r),
    .first_page(ring_first_page_r),
    .end_page(ring_end_page_r),
    .bnd_page(read_boundary_pointer_r),
    .next_page(link_page),
    .hits_bnd(link_hits_bnd)
  );

  rbm_page_link u_wpp_link (
    .cur_page(write_page_pointer_r),
    .first_page(ring_first_page_r),
    .end_page(ring_end_page_r),
    .bnd_page(read_boundary_pointer_r),
    .next_page(wpp_link_page),
    .hits_bnd(wpp_unused)
  );

  rbm_status_flags u_isr (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .set_bits(isr_set),
    .clr_we(reg_wr && !page1_sel && (reg_addr == `RBM_OFS_ISR)),
    .clr_bits(reg_wdata),
    .flags(isr_flags)
  );

  // ==========================================
  // receive dma state machine
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      page_r <= 8'h00;
      off_r <= 8'h00;
      count_r <= 16'h0000;
      pages_r <= 3'h0;
      hdr_status_r <= 8'h00;
      next_free_r <= 8'h00;
      mem_addr <= 16'h0000;
      mem_data <= 8'h00;
      mem_we <= 1'b0;
      write_page_pointer_r <= `RBM_RESET_PAGE;
      ring_full_r <= 1'b0;
      missed_r <= 8'h00;
      isr_set <= 8'h00;
      rx_busy <= 1'b0;
    end else if (ce) begin
      mem_we <= 1'b0;
      // transmit done lands on bit 1, transmit error on bit 3
      isr_set <= {4'h0, tx_error, 1'b0, tx_sent, 1'b0};
      case (state_r)
        ST_IDLE: begin
          rx_busy <= 1'b0;
          if (rx_start && rx_enabled) begin
            if (ring_full_r) begin
              // nothing free: frame is lost, stored frames untouched
              isr_set[`RBM_ISR_OVW] <= 1'b1;
              missed_r <= missed_r + 8'h01;
            end else begin
              page_r <= write_page_pointer_r;
              off_r <= `RBM_HDR_BYTES;
              count_r <= 16'h0000;
              pages_r <= 3'h1;
              rx_busy <= 1'b1;
              state_r <= ST_STORE;
            end
          end else if (rx_start && !halted_r) begin
            missed_r <= missed_r + 8'h01;
          end
        end
        ST_STORE: begin
          if (rx_valid) begin
            // check bytes arrive in the data stream and land right after it
            mem_addr <= page_addr(page_r, off_r);
            mem_data <= rx_byte;
            mem_we <= 1'b1;
            count_r <= count_r + 16'h0001;
            off_r <= off_r + 8'h01;
            if (off_r == `RBM_PAGE_LAST) begin
              if (link_hits_bnd) begin
                // abort before touching unread pages
                isr_set[`RBM_ISR_OVW] <= 1'b1;
                if (!halted_r) begin
                  missed_r <= missed_r + 8'h01;
                end
                page_r <= write_page_pointer_r;
                state_r <= ST_IDLE;
              end else begin
                page_r <= link_page;
                // 1518 bytes plus header always fits in six pages
                pages_r <= (pages_r == `RBM_MAX_PAGES) ? pages_r : pages_r + 3'h1;
              end
            end
          end else if (rx_end) begin
            if (reject) begin
              page_r <= write_page_pointer_r;
              isr_set[`RBM_ISR_RX_ERR] <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              hdr_status_r <= rx_status;
              next_free_r <= end_next_free;
              state_r <= ST_HDR0;
            end
          end
        end
        ST_HDR0: begin
          mem_addr <= page_addr(write_page_pointer_r, 8'h00);
          mem_data <= hdr_status_r;
          mem_we <= 1'b1;
          state_r <= ST_HDR1;
        end
        ST_HDR1: begin
          mem_addr <= page_addr(write_page_pointer_r, 8'h01);
          mem_data <= next_free_r;
          mem_we <= 1'b1;
          state_r <= ST_HDR2;
        end
        ST_HDR2: begin
          mem_addr <= page_addr(write_page_pointer_r, 8'h02);
          mem_data <= count_r[7:0];
          mem_we <= 1'b1;
          state_r <= ST_HDR3;
        end
        ST_HDR3: begin
          mem_addr <= page_addr(write_page_pointer_r, 8'h03);
          mem_data <= count_r[15:8];
          mem_we <= 1'b1;
          write_page_pointer_r <= next_free_r;
          // write side caught up with the read side: ring is full
          ring_full_r <= (next_free_r == read_boundary_pointer_r);
          isr_set[`RBM_ISR_RX_OK] <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      // host register writes to the working pointers and the missed tally
      if (reg_wr && page1_sel && (reg_addr == `RBM_OFS_WPP)) begin
        write_page_pointer_r <= reg_wdata;
        ring_full_r <= 1'b0;
      end
      if (reg_wr && !page1_sel && (reg_addr == `RBM_OFS_BND)) begin
        // read side moved: the ring is no longer full
        ring_full_r <= 1'b0;
      end
      if (reg_wr && !page1_sel && (reg_addr == `RBM_OFS_MISSED)) begin
        missed_r <= 8'h00;
      end
    end
  end

  // ==========================================
  // control registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= `RBM_CMD_RESET;
      halted_r <= 1'b1;
      ring_first_page_r <= `RBM_RESET_PAGE;
      ring_end_page_r <= 8'h00;
      read_boundary_pointer_r <= `RBM_RESET_PAGE;
      remote_count_low_r <= 8'h00;
      remote_count_high_r <= 8'h00;
      data_config_r <= 8'h00;
      tcfg_r <= 8'h00;
      receive_config_r <= 8'h00;
      interrupt_mask_r <= 8'h00;
      remote_dma_en <= 1'b0;
    end else if (ce) begin
      if (reg_wr && (reg_addr == `RBM_OFS_CMD)) begin
        cmd_r <= reg_wdata;
        if (reg_wdata[`RBM_CMD_HALT]) begin
          // a frame in progress still finishes
          halted_r <= 1'b1;
          remote_dma_en <= 1'b0;
        end else if (reg_wdata[`RBM_CMD_START]) begin
          halted_r <= 1'b0;
          remote_dma_en <= 1'b1;
        end
      end else if (reg_wr && !page1_sel) begin
        case (reg_addr)
          `RBM_OFS_FIRST: ring_first_page_r <= reg_wdata;
          `RBM_OFS_END: ring_end_page_r <= reg_wdata;
          `RBM_OFS_BND: read_boundary_pointer_r <= reg_wdata;
          `RBM_OFS_RCNT_LO: remote_count_low_r <= reg_wdata;
          `RBM_OFS_RCNT_HI: remote_count_high_r <= reg_wdata;
          `RBM_OFS_DCFG: data_config_r <= reg_wdata;
          `RBM_OFS_TCFG: tcfg_r <= reg_wdata;
          `RBM_OFS_RCFG: receive_config_r <= reg_wdata;
          `RBM_OFS_IMASK: interrupt_mask_r <= reg_wdata;
          default: begin
          end
        endcase
      end
      // transmit pending drops when the send finishes either way
      if (tx_sent || tx_error) begin
        cmd_r[`RBM_CMD_TXP] <= 1'b0;
      end
    end
  end

  // station address and multicast filter bytes
  always @(posedge mclk) begin
    if (ce && reg_wr && page1_sel && (reg_addr != `RBM_OFS_CMD) &&
        (reg_addr != `RBM_OFS_WPP)) begin
      addr_book_r[reg_addr - 4'h1] <= reg_wdata;
    end
  end

  // ==========================================
  // read port, data one cycle after the strobe
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        if (reg_addr == `RBM_OFS_CMD) begin
          reg_rdata <= cmd_r;
        end else if (page1_sel) begin
          if (reg_addr == `RBM_OFS_WPP) begin
            reg_rdata <= write_page_pointer_r;
          end else begin
            reg_rdata <= addr_book_r[reg_addr - 4'h1];
          end
        end else begin
          case (reg_addr)
            `RBM_OFS_FIRST: reg_rdata <= ring_first_page_r;
            `RBM_OFS_END: reg_rdata <= ring_end_page_r;
            `RBM_OFS_BND: reg_rdata <= read_boundary_pointer_r;
            `RBM_OFS_ISR: reg_rdata <= isr_flags |
                {halted_r && (state_r == ST_IDLE), 7'h00};
            `RBM_OFS_RCNT_LO: reg_rdata <= remote_count_low_r;
            `RBM_OFS_RCNT_HI: reg_rdata <= remote_count_high_r;
            `RBM_OFS_DCFG: reg_rdata <= data_config_r;
            `RBM_OFS_TCFG: reg_rdata <= tcfg_r;
            `RBM_OFS_RCFG: reg_rdata <= receive_config_r;
            `RBM_OFS_IMASK: reg_rdata <= interrupt_mask_r;
            `RBM_OFS_MISSED: reg_rdata <= missed_r;
            `RBM_OFS_RSTAT: reg_rdata <= {4'h0, pages_r == `RBM_MAX_PAGES,
                (write_page_pointer_r == read_boundary_pointer_r) && !ring_full_r,
                ring_full_r, wpp_link_page == read_boundary_pointer_r};
            default: reg_rdata <= 8'h00;
          endcase
        end
      end
    end
  end
endmodule // rbm_ring_manager

// ===== rbm_ring_manager_asserts.sv
// port-level assertion checker for the receive buffer ring manager
`timescale 1ns/10ps
`include "rbm_defines.vh"
module rbm_ring_chk (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire rx_start,
  input wire rx_valid,
  input wire [7:0] rx_byte,
  input wire rx_end,
  input wire [7:0] rx_status,
  input wire rx_runt,
  input wire rx_crc_err,
  input wire rx_align_err,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_data,
  input wire mem_we,
  input wire remote_dma_en,
  input wire rx_busy
);
  // ==========================================
  // shadow registers tracked from bus writes, plus a byte count from the receive stream
  reg [7:0] cmd_r;
  reg [7:0] first_r;
  reg [7:0] end_r;
  reg [7:0] bnd_r;
  reg [2:1] tcfg_r;
  reg acc_r;
  reg [15:0] cnt_r;
  wire [7:0] inc_pg;
  wire [7:0] nxt_pg;
  wire p0_wr;
  assign inc_pg = mem_addr[15:8] + 8'h01;
  assign nxt_pg = (inc_pg == end_r) ? first_r : inc_pg;
  assign p0_wr = ce && reg_wr && cmd_r[7:6] != 2'b01;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= `RBM_CMD_RESET;
      first_r <= `RBM_RESET_PAGE;
      end_r <= 8'h00;
      bnd_r <= `RBM_RESET_PAGE;
      tcfg_r <= 2'b00;
      acc_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else if (ce) begin
      if (reg_wr && reg_addr == `RBM_OFS_CMD) cmd_r <= reg_wdata;
      if (p0_wr && reg_addr == `RBM_OFS_FIRST) first_r <= reg_wdata;
      if (p0_wr && reg_addr == `RBM_OFS_END) end_r <= reg_wdata;
      if (p0_wr && reg_addr == `RBM_OFS_BND) bnd_r <= reg_wdata;
      if (p0_wr && reg_addr == `RBM_OFS_TCFG) tcfg_r <= reg_wdata[2:1];
      if (p0_wr && reg_addr == `RBM_OFS_RCFG) acc_r <= reg_wdata[`RBM_RCFG_ACC_ERR];
      if (rx_start) cnt_r <= 16'h0000;
      else if (rx_valid && rx_busy) cnt_r <= cnt_r + 16'h0001;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_cross;
    mem_we && mem_addr[7:0] == `RBM_PAGE_LAST ##1 mem_we && $past(rx_valid);
  endsequence
  sequence s_header;
    mem_we && mem_addr[7:0] == 8'h00 && mem_data == $past(rx_status, 2)
    ##1 mem_we && mem_addr[7:0] == 8'h01
    ##1 mem_we && mem_addr[7:0] == 8'h02 && mem_data == cnt_r[7:0]
    ##1 mem_we && mem_addr[7:0] == 8'h03 && mem_data == cnt_r[15:8];
  endsequence
  a_first_offset: assert property (
    $rose(rx_busy) && rx_valid |=> mem_we && mem_addr[7:0] == `RBM_HDR_BYTES
      && mem_data == $past(rx_byte)) else $error("first byte misplaced");
  a_data_order: assert property (
    mem_we ##1 mem_we && mem_addr[7:0] != 8'h00 |-> mem_addr == $past(mem_addr) + 16'h0001)
    else $error("buffer writes not consecutive");
  a_page_link: assert property (
    s_cross |-> mem_addr == {$past(nxt_pg), 8'h00}) else $error("wrong page linked");
  a_ovf_abort: assert property (
    mem_we && mem_addr[7:0] == `RBM_PAGE_LAST && rx_busy && nxt_pg == bnd_r |=> !mem_we [*4])
    else $error("write crossed the read boundary");
  a_header_write: assert property (
    rx_end && rx_busy && !rx_runt && (acc_r || !(rx_crc_err || rx_align_err)) |=> ##1 s_header)
    else $error("frame header wrong");
  a_reject_frame: assert property (
    rx_end && rx_busy && !acc_r && (rx_crc_err || rx_align_err) |=> !mem_we [*4])
    else $error("rejected frame got a header");
  a_remote_on: assert property (
    ce && reg_wr && reg_addr == `RBM_OFS_CMD && reg_wdata[1:0] == 2'b10 |=> remote_dma_en)
    else $error("start did not enable remote dma");
  a_remote_off: assert property (
    ce && reg_wr && reg_addr == `RBM_OFS_CMD && reg_wdata[0] |=> !remote_dma_en)
    else $error("halt left remote dma on");
  a_rx_held: assert property (
    !rx_busy && (cmd_r[`RBM_CMD_HALT] || tcfg_r != 2'b00) |=> !rx_busy)
    else $error("receive dma ran while halted or looped");
  a_read_idle: assert property (
    $past(ce) && !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");
endmodule // rbm_ring_chk
bind rbm_ring_manager rbm_ring_chk u_chk (.*);

// ===== rbm_ring_manager_test.sv
// self-checking testbench for the receive buffer ring manager
`timescale 1ns/10ps
`include "rbm_defines.vh"
module rbm_ring_manager_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_start = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic rx_end = 1'b0;
  logic [7:0] rx_status = 8'h00;
  logic rx_runt = 1'b0;
  logic rx_crc_err = 1'b0;
  logic rx_align_err = 1'b0;
  logic tx_sent = 1'b0;
  logic tx_error = 1'b0;
  wire [7:0] reg_rdata;
  wire [15:0] mem_addr;
  wire [7:0] mem_data;
  wire mem_we;
  wire remote_dma_en;
  wire rx_busy;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] v;
  logic transmit_pending_bit;
  logic resend;
  always #5 mclk = ~mclk;
  rbm_ring_manager DUT (.*);
  rbm_mem_model MEM (.*);
  // ==========================================
  // bus, stream and compare tasks
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    check($sformatf("register %h", a), v, e);
  endtask
  task automatic wpp_is(input logic [7:0] e);
    wr(`RBM_OFS_CMD, 8'h62);
    rdc(`RBM_OFS_WPP, e);
    wr(`RBM_OFS_CMD, 8'h22);
  endtask
  // one frame: payload bytes are index xor seed, bad marks a crc error
  task automatic send(input int n, input logic [7:0] sd, input logic bad);
    int i;
    @(posedge mclk);
    rx_start <= 1'b1;
    @(posedge mclk);
    rx_start <= 1'b0;
    for (i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_byte <= i[7:0] ^ sd;
      @(posedge mclk);
    end
    rx_valid <= 1'b0;
    @(posedge mclk);
    rx_end <= 1'b1;
    rx_status <= 8'h01;
    rx_crc_err <= bad;
    @(posedge mclk);
    rx_end <= 1'b0;
    rx_crc_err <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
  task automatic hdr(input logic [7:0] pg, input logic [7:0] nx, input logic [15:0] n);
    check("status", MEM.mem_r[{pg, 8'h00}], 8'h01);
    check("next page", MEM.mem_r[{pg, 8'h01}], nx);
    check("count", {MEM.mem_r[{pg, 8'h03}], MEM.mem_r[{pg, 8'h02}]}, n);
  endtask
  task stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(`RBM_OFS_CMD, 8'h21);
    rdc(`RBM_OFS_FIRST, `RBM_RESET_PAGE);
    rdc(`RBM_OFS_BND, `RBM_RESET_PAGE);
    rdc(4'hD, 8'h00);
    $display("test reset done");
    wr(`RBM_OFS_RCNT_LO, 8'h00);
    wr(`RBM_OFS_TCFG, 8'h02);
    wr(`RBM_OFS_END, 8'h48);
    wr(`RBM_OFS_ISR, 8'hFF);
    rd(`RBM_OFS_ISR);
    check("isr cleared", v[6:0], 7'h00);
    wr(`RBM_OFS_CMD, 8'h61);
    wr(`RBM_OFS_WPP, 8'h40);
    rdc(`RBM_OFS_WPP, 8'h40);
    wr(`RBM_OFS_CMD, 8'h22);
    #1 check("remote on", remote_dma_en, 1'b1);
    send(20, 8'h11, 1'b0);
    check("loopback writes", MEM.n_wr[15:0], 16'h0000);
    wr(`RBM_OFS_TCFG, 8'h00);
    $display("test bring-up done");
    send(60, 8'hA5, 1'b0);
    hdr(8'h40, 8'h41, 16'h003C);
    check("first byte", MEM.mem_r[16'h4004], 8'hA5);
    check("last byte", MEM.mem_r[16'h403F], 8'h3B ^ 8'hA5);
    wpp_is(8'h41);
    wr(`RBM_OFS_BND, 8'h41);
    rd(`RBM_OFS_RSTAT);
    check("ring empty", v[2:1], 2'b10);
    send(1518, 8'h3C, 1'b0);
    hdr(8'h41, 8'h47, 16'h05EE);
    check("linked byte", MEM.mem_r[16'h4200], 8'hFC ^ 8'h3C);
    rd(`RBM_OFS_RSTAT);
    check("six pages", v[3:0], 4'h8);
    send(400, 8'h5A, 1'b0);
    hdr(8'h47, 8'h41, 16'h0190);
    check("wrapped byte", MEM.mem_r[16'h4000], 8'hFC ^ 8'h5A);
    rd(`RBM_OFS_RSTAT);
    check("ring full", v[2:1], 2'b01);
    $display("test linking done");
    wr(`RBM_OFS_BND, 8'h43);
    send(600, 8'h77, 1'b1);
    rd(`RBM_OFS_ISR);
    check("overwrite flag", v[`RBM_ISR_OVW], 1'b1);
    check("kept frame", MEM.mem_r[16'h4310], 8'h0C ^ 8'h3C);
    wpp_is(8'h41);
    $display("test overflow done");
    wr(`RBM_OFS_CMD, 8'h26);
    rd(`RBM_OFS_CMD);
    transmit_pending_bit = v[`RBM_CMD_TXP];
    check("transmit pending", transmit_pending_bit, 1'b1);
    wr(`RBM_OFS_CMD, 8'h21);
    #1 check("remote off", remote_dma_en, 1'b0);
    wr(`RBM_OFS_MISSED, 8'h00);
    send(10, 8'h01, 1'b0);
    rdc(`RBM_OFS_MISSED, 8'h00);
    // settle time cut well below 1.6 ms: nothing is in flight here
    repeat (200) @(posedge mclk);
    wr(`RBM_OFS_RCNT_LO, 8'h00);
    wr(`RBM_OFS_RCNT_HI, 8'h00);
    rd(`RBM_OFS_ISR);
    resend = transmit_pending_bit && !v[`RBM_ISR_SENT] && !v[`RBM_ISR_SEND_ERR];
    wr(`RBM_OFS_TCFG, 8'h04);
    wr(`RBM_OFS_CMD, 8'h22);
    send(10, 8'h02, 1'b0);
    wr(`RBM_OFS_ISR, 8'h10);
    rd(`RBM_OFS_ISR);
    check("overwrite cleared", v[`RBM_ISR_OVW], 1'b0);
    wr(`RBM_OFS_TCFG, 8'h00);
    if (resend) wr(`RBM_OFS_CMD, 8'h26);
    rdc(`RBM_OFS_CMD, 8'h26);
    @(posedge mclk);
    tx_sent <= 1'b1;
    @(posedge mclk);
    tx_sent <= 1'b0;
    tx_error <= 1'b1;
    @(posedge mclk);
    tx_error <= 1'b0;
    rdc(`RBM_OFS_CMD, 8'h22);
    rd(`RBM_OFS_ISR);
    check("send flags", {v[`RBM_ISR_SEND_ERR], v[`RBM_ISR_SENT]}, 2'b11);
    $display("test recovery done");
    wr(`RBM_OFS_ISR, 8'hFF);
    send(30, 8'h44, 1'b1);
    rd(`RBM_OFS_ISR);
    check("receive error", v[`RBM_ISR_RX_ERR], 1'b1);
    wpp_is(8'h41);
    wr(`RBM_OFS_RCFG, 8'h01);
    send(30, 8'h44, 1'b1);
    hdr(8'h41, 8'h42, 16'h001E);
    wpp_is(8'h42);
    wr(`RBM_OFS_ISR, 8'hFF);
    rx_runt <= 1'b1;
    send(20, 8'h55, 1'b0);
    rx_runt <= 1'b0;
    rd(`RBM_OFS_ISR);
    check("runt rejected", v[`RBM_ISR_RX_ERR], 1'b1);
    wpp_is(8'h42);
    // clock enable low must drop the write
    @(posedge mclk);
    ce <= 1'b0;
    wr(`RBM_OFS_BND, 8'h44);
    ce <= 1'b1;
    rdc(`RBM_OFS_BND, 8'h43);
    $display("test reject done");
    stop_test;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    failures++;
    $display("wrong value run length expected finish seen timeout");
    stop_test;
  end
endmodule // rbm_ring_manager_test

// ===== rbm_status_flags.v
// sticky interrupt status flags, write one to clear
`timescale 1ns/10ps
module rbm_status_flags (
  mclk,
  rst_n,
  ce,
  set_bits,
  clr_we,
  clr_bits,
  flags
);
  input wire mclk;
  input wire rst_n;
  input wire ce;
  input wire [7:0] set_bits;
  input wire clr_we;
  input wire [7:0] clr_bits;
  output wire [7:0] flags;
  reg [7:0] flags_r;
  wire [7:0] flags_nxt;
  // a set in the clearing cycle survives
  assign flags_nxt = (flags_r & ~(clr_we ? clr_bits : 8'h00)) | set_bits;
  assign flags = flags_r;
  // ==========================================
  // storage
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= 8'h00;
    end else if (ce) begin
      flags_r <= flags_nxt;
    end
  end
endmodule // rbm_status_flags
